/* File: testbench/tsa_host_model.sv */
// Serial host model: drives select, serial clock and both serial words.
// Assumes start is a one-cycle pulse set just after a pclk edge.
`timescale 1ns/10ps
module tsa_host_model
  import tsa_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           start,
  input  wire tsa_slot_word_t slot_word,
  input  wire tsa_addr_word_t addr_word,
  input  wire logic [3:0]     n_bits,
  input  wire logic           wait_ack,
  input  wire logic           ack_line,
  output logic                device_select,
  output logic                serial_clock,
  output logic                slot_mode_serial_in,
  output logic                addr_status_serial_in,
  output logic                busy
);
  localparam int HALF = 8;  // Half serial period, slow against the syncs
  int i;
  // Idle state: deselected, serial clock parked low
  initial begin
    device_select = 1'h0;
    serial_clock = 1'h0;
    busy = 1'h0;
    slot_mode_serial_in = 1'h0;
    addr_status_serial_in = 1'h1;
  end
  // One access; data moves at the rise so it is settled at the fall
  always begin
    @(posedge pclk);
    if (start) begin
      busy <= 1'h1;
      device_select <= 1'h1;
      repeat (HALF) @(posedge pclk);
      for (i = 0; i < int'(n_bits); i++) begin
        slot_mode_serial_in <= slot_word[3'(7 - i)];
        addr_status_serial_in <= addr_word[3'(7 - i)];
        serial_clock <= 1'h1;
        repeat (HALF) @(posedge pclk);
        serial_clock <= 1'h0;
        repeat (HALF) @(posedge pclk);
      end
      // Hold select until the shared line drops; the bench watchdog
      // ends the run if it never does
      while (wait_ack && ack_line) @(posedge pclk);
      device_select <= 1'h0;
      slot_mode_serial_in <= ~slot_mode_serial_in;
      addr_status_serial_in <= ~addr_status_serial_in;
      busy <= 1'h0;
    end
  end
endmodule : tsa_host_model

/* File: testbench/tsa_slot_assigner_test.sv */
// Bench for the slot assigner: APB master, codec timing, host model and
// a frame-position reference model compared at mid-bit of every bit.
// Assumes one wait state on APB and a few pclk of pin sync latency.
`timescale 1ns/10ps
module tsa_slot_assigner_test;
  import tsa_pkg::*;
  logic           pclk = 1'h0;
  logic           presetn = 1'h0;
  logic           psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0]    paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [31:0]    prdata, rd;
  logic           pready, pslverr, er, dsel, sclk, sm_in, as_in, busy;
  logic [4:0]     bank = 5'h00;
  logic           s2_clr = 1'h0, start = 1'h0, wait_ack = 1'h0;
  logic [2:0]     st_out;
  logic           tx_en, rx_en, ack_out, ack_oe, ack_line;
  logic [3:0]     n_bits = 4'h8;
  tsa_slot_word_t sw = '0;
  tsa_addr_word_t aw = '0;
  int ph = 0, bit_no = 0, n_mismatch = 0, samples_checked = 0;
  int tx_slot = 0, rx_slot = 0, tx_on = 0, rx_on = 0, st = 0, run = 0;
  int rx_ok = 0, ack_fr = 0, n_acc = 0, single = 0, mon = 0;
  int md_now = 3, stw = 0;
  int pq[$];
  int modes[7] = '{0, 1, 2, 3, 2, 1, 0};

  always #2 pclk = ~pclk;
  // Codec timing: ten pclk to a bit clock, 64 bits to a frame
  always @(posedge pclk) begin
    ph <= (ph == 9) ? 0 : ph + 1;
    if (ph == 9) bit_no <= (bit_no + 1) % 64;
  end
  wire bclk  = ph < 5;
  wire tx_fs = (bit_no == 63 && ph > 6) || (bit_no == 0 && ph < 7);
  wire rx_fs = (bit_no == 15 && ph > 6) || (bit_no == 16 && ph < 7);
  assign ack_line = ack_oe ? ack_out : 1'h1;  // Weak pull-up when released

  tsa_slot_assigner i_tsa_slot_assigner (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .device_select(dsel), .serial_clock(sclk), .slot_mode_serial_in(sm_in),
    .addr_status_serial_in(as_in), .hardwired_bank_address(bank),
    .bit_clock_a(bclk), .bit_clock_b(bclk), .tx_frame_sync(tx_fs),
    .rx_frame_sync(rx_fs), .status2_clear(s2_clr),
    .status_out_0(st_out[0]), .status_out_1(st_out[1]),
    .status_out_2(st_out[2]), .tx_slot_enable(tx_en),
    .rx_slot_enable(rx_en), .ack_out(ack_out), .ack_oe(ack_oe));
  tsa_host_model i_tsa_host_model (.pclk(pclk), .start(start),
    .slot_word(sw), .addr_word(aw), .n_bits(n_bits), .wait_ack(wait_ack),
    .ack_line(ack_line), .device_select(dsel), .serial_clock(sclk),
    .slot_mode_serial_in(sm_in), .addr_status_serial_in(as_in),
    .busy(busy));

  // Compare tasks, one per kind of result
  task automatic chk_pin(input logic got, input int exp, input string w);
    samples_checked++;
    if (got !== (exp != 0)) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %b", $time, w, got);
    end
  endtask : chk_pin
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp,
                         input string w);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk_reg
  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= 32'(a);
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);  // Idle cycle keeps back-to-back calls apart
  endtask : apb
  task automatic wait_at(input int b);
    do @(posedge pclk); while (!(bit_no == b && ph == 0));
  endtask : wait_at
  // Reference update at the frame sync that follows an accepted load
  task automatic apply(input int w);
    int md;
    int sl;
    md = w / 512;
    sl = (w / 8) % 64;
    st = w % 8;
    md_now = md;
    if (run == 0) rx_ok = 0;  // Stopped counters realign at rx sync
    run = md != 3;
    if (md < 2) tx_slot = sl;
    if (md % 2 == 0) rx_slot = sl;
    if (md < 2) tx_on = 1;
    if (md == 3) tx_on = 0;
    rx_on = run;
  endtask : apply
  // Loads start at bit 8 so they finish well before the next sync
  task automatic load(input int md, input int sl, input int stv,
                      input logic [4:0] ad, input int nb);
    logic acc;
    acc = nb == 8 && (ad == bank || single != 0);
    wait_at(8);
    sw <= {2'(md), 6'(sl)};
    aw <= {3'(stv), ad};
    n_bits <= 4'(nb);
    wait_ack <= acc;
    start <= 1'h1;
    if (acc) pq.push_back(md * 512 + sl * 8 + stv);
    if (acc) n_acc++;
    @(posedge pclk);
    start <= 1'h0;
    repeat (2) @(posedge pclk);
    while (busy === 1'h1) @(posedge pclk);
    $display("load mode %0d bits %0d done", md, nb);
  endtask : load
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // Model steps at frame start; pins compared once settled, mid-bit
  always @(posedge pclk) begin
    if (mon && bit_no == 16 && ph == 5) rx_ok = 1;
    if (mon && bit_no == 0 && ph == 5) begin
      ack_fr = pq.size() > 0;
      if (ack_fr) apply(pq.pop_front());
    end
    if (mon && ph == 7) begin
      chk_pin(tx_en, tx_on && bit_no / 8 == tx_slot, "tx");
      if (rx_ok) chk_pin(rx_en, rx_on && (bit_no + 48) % 64 / 8 == rx_slot,
                         "rx");
      chk_pin(st_out[0], st % 2, "status0");
      chk_pin(st_out[1], st / 2 % 2, "status1");
      chk_pin(st_out[2], st / 4, "status2");
      if (bit_no != 2 && bit_no != 63)
        chk_pin(ack_oe, ack_fr && bit_no > 2, "ack");
      chk_pin(ack_out, 0, "ack drive");
    end
  end

  // Watchdog: the sequence needs about 15 frames of 640 pclk
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    stop_test;
  end

  initial begin
    void'($urandom(32'h0000_362d));
    bank <= 5'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    mon = 1;
    apb(1'h0, TSA_ADDR_CTRL, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000, "ctrl reset");
    apb(1'h0, 8'h0c, 32'h0000_0000);
    chk_pin(er, 1, "unmapped error");
    chk_reg(rd, 32'h0000_0000, "unmapped data");
    $display("test registers done");
    foreach (modes[j])
      load(modes[j], $urandom % 8, $urandom % 8, bank, 8);
    load(0, 5, 7, bank ^ 5'h01, 8);
    load(0, 6, 2, bank, 7);
    load(0, 6, 2, bank, 9);
    $display("test refusals done");
    apb(1'h1, TSA_ADDR_CTRL, 32'h0000_0001);
    single = 1;
    load(1, 4, 7, bank ^ 5'h1f, 8);
    apb(1'h1, TSA_ADDR_CTRL, 32'h0000_0000);
    single = 0;
    $display("test single device done");
    wait_at(30);
    s2_clr <= 1'h1;
    st = st % 4;
    repeat (2) @(posedge pclk);
    chk_pin(st_out[2], 0, "status2 clear");
    repeat (20) @(posedge pclk);
    s2_clr <= 1'h0;
    load(2, 7, 5, bank, 8);
    apb(1'h0, TSA_ADDR_COUNT, 32'h0000_0000);
    chk_reg(rd, 32'(n_acc), "load count");
    apb(1'h0, TSA_ADDR_STATUS, 32'h0000_0000);
    stw = st << 19 | ack_fr << 18 | run << 16 | rx_on << 15 | tx_on << 14;
    stw = stw | md_now << 12 | rx_slot << 6 | tx_slot;
    chk_reg(rd, 32'(stw), "status image");
    $display("test clear and count done");
    stop_test;
  end
endmodule : tsa_slot_assigner_test

/* File: verilog/tsa_pkg.sv */
// Constants, pin groups and word layouts for the time slot assigner.
// Assumes one 250 MHz clock; every pin of the serial port and the codec
// timing pins is asynchronous to it and is synchronised before use.
package tsa_pkg;

  // Serial word framing
  localparam logic [3:0] TSA_BIT_LAST = 4'h7;   // Eighth bit of a word
  localparam logic [3:0] TSA_BIT_OVER = 4'h8;   // A ninth bit spoils a load

  // Time slot arithmetic: eight bit clocks to a slot, 64 slots
  localparam logic [2:0] TSA_SLOT_BIT_LAST = 3'h7;
  localparam logic [5:0] TSA_SLOT_LAST     = 6'h3f;

  // Acknowledge goes low on the third bit clock after the frame sync
  localparam logic [1:0] TSA_ACK_DELAY_LAST = 2'h2;

  // Programming modes, first received bit is the high bit
  localparam logic [1:0] TSA_MODE_BOTH = 2'h0;
  localparam logic [1:0] TSA_MODE_TX   = 2'h1;
  localparam logic [1:0] TSA_MODE_RX   = 2'h2;
  localparam logic [1:0] TSA_MODE_IDLE = 2'h3;

  // APB register byte offsets
  localparam logic [7:0] TSA_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] TSA_ADDR_STATUS = 8'h04;
  localparam logic [7:0] TSA_ADDR_COUNT  = 8'h08;
  localparam int         TSA_CTRL_SINGLE = 0;    // Bit: single-device mode
  localparam logic       TSA_CTRL_RESET  = 1'b0;

  // Pins that cross into the pclk domain together
  typedef struct packed {
    logic       sel;
    logic       sclk;
    logic       slot_mode;
    logic       addr_status;
    logic       bclk_a;
    logic       bclk_b;
    logic       tx_fs;
    logic       rx_fs;
    logic [4:0] bank_addr;
  } tsa_pins_t;

  // Slot/mode word as shifted in, first bit at the top
  typedef struct packed {
    logic [1:0] mode;
    logic [5:0] slot;
  } tsa_slot_word_t;

  // Address/status word as shifted in, first bit at the top
  typedef struct packed {
    logic [2:0] status;
    logic [4:0] addr;
  } tsa_addr_word_t;

  // Status register image, high bits first
  typedef struct packed {
    logic [2:0] status;
    logic       ack;
    logic       pending;
    logic       run;
    logic       rx_on;
    logic       tx_on;
    logic [1:0] mode;
    logic [5:0] rx_slot;
    logic [5:0] tx_slot;
  } tsa_status_t;

  typedef enum logic [2:0] {
    TSA_ACK_IDLE = 3'b001,
    TSA_ACK_WAIT = 3'b010,
    TSA_ACK_LOW  = 3'b100
  } tsa_ack_state_t;

  // Edge detectors on synchronised levels
  function automatic logic tsa_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction : tsa_rise

  function automatic logic tsa_fall(input logic cur, input logic prev);
    return ~cur & prev;
  endfunction : tsa_fall

endpackage : tsa_pkg

/* File: verilog/tsa_slot_assigner.sv */
// Time slot assigner top: serial programming port, status outputs,
// open-drain acknowledge, transmit and receive slot enables, APB regs.
// Assumes all port and codec pins are asynchronous to pclk and slow
// against it; the APB master runs on pclk.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
module tsa_slot_assigner
  import tsa_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        device_select,
  input  wire logic        serial_clock,
  input  wire logic        slot_mode_serial_in,
  input  wire logic        addr_status_serial_in,
  input  wire logic [4:0]  hardwired_bank_address,
  input  wire logic        bit_clock_a,
  input  wire logic        bit_clock_b,
  input  wire logic        tx_frame_sync,
  input  wire logic        rx_frame_sync,
  input  wire logic        status2_clear,
  output logic             status_out_0,
  output logic             status_out_1,
  output logic             status_out_2,
  output logic             tx_slot_enable,
  output logic             rx_slot_enable,
  output logic             ack_out,
  output logic             ack_oe
);

  tsa_pins_t       pins_async;
  tsa_pins_t       pins;
  tsa_pins_t       pins_q;
  tsa_slot_word_t  sm_sr;
  tsa_addr_word_t  as_sr;
  tsa_slot_word_t  held_sm;
  tsa_addr_word_t  held_as;
  tsa_ack_state_t  ack_state;
  logic [3:0]      bit_cnt;
  logic            pending;
  logic [5:0]      tx_slot;
  logic [5:0]      rx_slot;
  logic [1:0]      mode;
  logic            tx_on;
  logic            rx_on;
  logic            run;
  logic [1:0]      ack_cnt;
  logic            single_device;
  logic [7:0]      load_count;

  // Whole serial group crosses together through the same synchroniser
  assign pins_async = '{sel:         device_select,
                        sclk:        serial_clock,
                        slot_mode:   slot_mode_serial_in,
                        addr_status: addr_status_serial_in,
                        bclk_a:      bit_clock_a,
                        bclk_b:      bit_clock_b,
                        tx_fs:       tx_frame_sync,
                        rx_fs:       rx_frame_sync,
                        bank_addr:   hardwired_bank_address};

  tsa_sync2 #(
    .WIDTH ($bits(tsa_pins_t))
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (pins_async),
    .sync_out (pins)
  );

  // Previous synchronised levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins;
    end
  end

  // Edge pulses and the next shifted words
  wire sclk_fall  = tsa_fall(pins.sclk, pins_q.sclk);
  wire txb_rise   = tsa_rise(pins.bclk_a, pins_q.bclk_a);
  wire rxb_rise   = tsa_rise(pins.bclk_b, pins_q.bclk_b);
  wire tx_fs_rise = tsa_rise(pins.tx_fs, pins_q.tx_fs);
  wire rx_fs_rise = tsa_rise(pins.rx_fs, pins_q.rx_fs);
  wire shift_now  = pins.sel & sclk_fall;
  tsa_slot_word_t next_sm;
  tsa_addr_word_t next_as;
  assign next_sm = {sm_sr[6:0], pins.slot_mode};
  assign next_as = {as_sr[6:0], pins.addr_status};

  // Acceptance: eighth bit with matching address, or single-device mode
  wire addr_ok    = single_device
                  | (next_as.addr == pins.bank_addr);
  wire accept_now = shift_now & (bit_cnt == TSA_BIT_LAST) & addr_ok;
  wire overrun    = shift_now & (bit_cnt == TSA_BIT_OVER);
  wire apply      = pending & tx_fs_rise;

  // Shift both words side by side; a deselect restarts the count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= '0;
      sm_sr   <= '0;
      as_sr   <= '0;
    end else if (!pins.sel) begin
      bit_cnt <= '0;
    end else if (sclk_fall) begin
      sm_sr <= next_sm;
      as_sr <= next_as;
      if (bit_cnt != TSA_BIT_OVER) begin
        bit_cnt <= bit_cnt + 4'd1;
      end
    end
  end

  // Pending load waits for the frame sync; a new accept beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
      held_sm <= '0;
      held_as <= '0;
    end else if (accept_now) begin
      pending <= 1'b1;
      held_sm <= next_sm;
      held_as <= next_as;
    end else if (apply || overrun) begin
      pending <= 1'b0;
    end
  end

  // Apply accepted words at the transmit frame sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_slot <= '0;
      rx_slot <= '0;
      mode    <= TSA_MODE_IDLE;
      tx_on   <= 1'b0;
      rx_on   <= 1'b0;
      run     <= 1'b0;
    end else if (apply) begin
      mode <= held_sm.mode;
      case (held_sm.mode)
        TSA_MODE_BOTH: begin
          tx_slot <= held_sm.slot;
          rx_slot <= held_sm.slot;
          tx_on   <= 1'b1;
          rx_on   <= 1'b1;
          run     <= 1'b1;
        end
        TSA_MODE_TX: begin
          tx_slot <= held_sm.slot;
          tx_on   <= 1'b1;
          rx_on   <= 1'b1;
          run     <= 1'b1;
        end
        TSA_MODE_RX: begin
          rx_slot <= held_sm.slot;
          rx_on   <= 1'b1;
          run     <= 1'b1;
        end
        default: begin
          tx_on <= 1'b0;
          rx_on <= 1'b0;
          run   <= 1'b0;
        end
      endcase
    end
  end

  // Status outputs 0 and 1 load with every applied word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out_0 <= 1'b0;
      status_out_1 <= 1'b0;
    end else if (apply) begin
      status_out_0 <= held_as.status[0];
      status_out_1 <= held_as.status[1];
    end
  end

  // Clear acts without the clock so a ring trip is never delayed
  always_ff @(posedge pclk or negedge presetn or posedge status2_clear)
  begin
    if (!presetn) begin
      status_out_2 <= 1'b0;
    end else if (status2_clear) begin
      status_out_2 <= 1'b0;
    end else if (apply) begin
      status_out_2 <= held_as.status[2];
    end
  end

  // Acknowledge sequencer: counts transmit bit clocks after the sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_state <= TSA_ACK_IDLE;
      ack_cnt   <= '0;
      ack_oe    <= 1'b0;
    end else if (apply) begin
      ack_state <= TSA_ACK_WAIT;
      ack_cnt   <= '0;
      ack_oe    <= 1'b0;
    end else begin
      case (ack_state)
        TSA_ACK_WAIT: begin
          if (txb_rise) begin
            ack_cnt <= ack_cnt + 2'd1;
            if (ack_cnt == TSA_ACK_DELAY_LAST) begin
              ack_state <= TSA_ACK_LOW;
              ack_oe    <= 1'b1;
            end
          end
        end
        TSA_ACK_LOW: begin
          if (tx_fs_rise) begin
            ack_state <= TSA_ACK_IDLE;
            ack_oe    <= 1'b0;
          end
        end
        default: begin
          ack_state <= TSA_ACK_IDLE;
          ack_oe    <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: data is always low, only the enable moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= 1'b0;
    end
  end

  // Two independent directions; receive may run from its own bit clock
  tsa_slot_gen u_tx_slot (
    .pclk      (pclk),
    .presetn   (presetn),
    .bclk_rise (txb_rise),
    .fs_rise   (tx_fs_rise),
    .run       (run),
    .dir_on    (tx_on),
    .slot_prog (tx_slot),
    .slot_en   (tx_slot_enable)
  );

  tsa_slot_gen u_rx_slot (
    .pclk      (pclk),
    .presetn   (presetn),
    .bclk_rise (rxb_rise),
    .fs_rise   (rx_fs_rise),
    .run       (run),
    .dir_on    (rx_on),
    .slot_prog (rx_slot),
    .slot_en   (rx_slot_enable)
  );

  // APB decode; one wait state so read data comes from a flip-flop
  wire         apb_acc  = psel & penable;
  wire         hit_ctrl = paddr[7:0] == TSA_ADDR_CTRL;
  wire         hit_stat = paddr[7:0] == TSA_ADDR_STATUS;
  wire         hit_cnt  = paddr[7:0] == TSA_ADDR_COUNT;
  wire         apb_hit  = (paddr[31:8] == 24'h00_0000)
                        & (hit_ctrl | hit_stat | hit_cnt);
  tsa_status_t stat_img;
  assign stat_img = '{status:  {status_out_2, status_out_1, status_out_0},
                      ack:     ack_oe,
                      pending: pending,
                      run:     run,
                      rx_on:   rx_on,
                      tx_on:   tx_on,
                      mode:    mode,
                      rx_slot: rx_slot,
                      tx_slot: tx_slot};
  wire  [31:0] rd_mux   = !apb_hit ? 32'h0000_0000 :
                          hit_ctrl ? {31'h0000_0000, single_device} :
                          hit_stat ? 32'(stat_img) :
                                     {24'h00_0000, load_count};

  // Answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~apb_hit;
      prdata  <= (apb_acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Control write at the completing edge; count loads that take effect,
  // so a load cancelled by a ninth bit is never counted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_device <= TSA_CTRL_RESET;
      load_count    <= '0;
    end else begin
      if (apb_acc && pready && pwrite && hit_ctrl && apb_hit) begin
        single_device <= pwdata[TSA_CTRL_SINGLE];
      end
      if (apply) begin
        load_count <= load_count + 8'd1;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_deselect_clears: assert property (
    !pins.sel |=> bit_cnt == 4'd0)
    else $error("Bit counter not cleared when deselected");

  a_accept_match: assert property (
    $rose(pending) |-> $past(addr_ok) && $past(bit_cnt) == TSA_BIT_LAST)
    else $error("Load accepted without match or eight bits");

  a_q2_cleared: assert property (
    status2_clear |-> !status_out_2)
    else $error("Status output 2 high during clear");

  a_ack_three_bits: assert property (
    $rose(ack_oe) |-> $past(txb_rise)
                      && $past(ack_cnt) == TSA_ACK_DELAY_LAST)
    else $error("Acknowledge not on third bit clock");

  a_ack_release_fs: assert property (
    ack_oe && tx_fs_rise |=> !ack_oe)
    else $error("Acknowledge not released at frame sync");

  a_ack_drive_low: assert property (
    ack_oe |-> !ack_out)
    else $error("Acknowledge driven high");

  a_slot_on_fs: assert property (
    $changed(tx_slot) || $changed(mode) |-> $past(tx_fs_rise))
    else $error("Slot or mode changed away from frame sync");

  a_idle_stops: assert property (
    apply && held_sm.mode == TSA_MODE_IDLE |=> !run ##2 !tx_slot_enable)
    else $error("Idle mode left counters running");

  a_apb_answer: assert property (
    apb_acc && !pready |=> pready)
    else $error("APB answer not in second access cycle");

endmodule : tsa_slot_assigner

/* File: verilog/tsa_slot_gen.sv */
// One direction's slot counter and slot enable output.
// Assumes bit clock and frame sync edges arrive as one-cycle pulses in
// the pclk domain; the frame sync edge marks bit zero of slot zero.
`timescale 1ns/10ps
module tsa_slot_gen
  import tsa_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       bclk_rise,
  input  wire logic       fs_rise,
  input  wire logic       run,
  input  wire logic       dir_on,
  input  wire logic [5:0] slot_prog,
  output logic            slot_en
);

  logic       fs_seen;
  logic       live;
  logic [2:0] bit_cnt;
  logic [5:0] slot_cnt;

  wire restart  = bclk_rise & (fs_seen | fs_rise);
  wire slot_end = bit_cnt == TSA_SLOT_BIT_LAST;

  // Remember a frame sync until the bit clock edge that starts slot zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_seen <= 1'b0;
    end else if (bclk_rise) begin
      fs_seen <= 1'b0;
    end else if (fs_rise) begin
      fs_seen <= 1'b1;
    end
  end

  // Divide the bit clock by eight; counting halts when idled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live     <= 1'b0;
      bit_cnt  <= '0;
      slot_cnt <= '0;
    end else if (!run) begin
      live <= 1'b0;
    end else if (restart) begin
      live     <= 1'b1;
      bit_cnt  <= '0;
      slot_cnt <= '0;
    end else if (bclk_rise && live) begin
      bit_cnt <= bit_cnt + 3'd1;
      if (slot_end) begin
        // No wrap: slot 63 is the last one before the next frame
        live     <= slot_cnt != TSA_SLOT_LAST;
        slot_cnt <= slot_cnt + 6'd1;
      end
    end
  end

  // High for the eight bit clocks of the programmed slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_en <= 1'b0;
    end else begin
      slot_en <= run & dir_on & live & (slot_cnt == slot_prog);
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_en_in_slot: assert property (
    slot_en |-> $past(live) && $past(slot_cnt) == $past(slot_prog))
    else $error("Slot enable outside the programmed slot");

  a_en_stops_idle: assert property (
    !run |=> !slot_en)
    else $error("Slot enable while idled");

endmodule : tsa_slot_gen

/* File: verilog/tsa_sync2.sv */
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is a slow level; multi-bit values must be static
// or tolerate one cycle of skew between bits.
`timescale 1ns/10ps
module tsa_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : tsa_sync2
